// ==== logic/pin_state_pkg.sv ====
// Constants, codes and helpers shared by the pin state control block.
`default_nettype none
package pin_state_pkg;

  // Pin and channel counts.
  localparam int NUM_PINS = 8;
  localparam int NUM_CHAN = 4;

  // Register byte offsets on the bus.
  localparam logic [4:0] CTRL_OFFSET = 5'h00;
  localparam logic [4:0] RELOC_OFFSET = 5'h04;
  localparam logic [4:0] FUNC_OFFSET = 5'h08;
  localparam logic [4:0] GPIO_OUT_OFFSET = 5'h0c;
  localparam logic [4:0] GPIO_DIR_OFFSET = 5'h10;
  localparam logic [4:0] PIN_IN_OFFSET = 5'h14;
  localparam logic [4:0] STATUS_OFFSET = 5'h18;

  // Control register field positions.
  localparam int CTRL_SPL_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_WAKE_BIT = 4;
  localparam int CTRL_SUBEXT_BIT = 5;

  // Status register field positions.
  localparam int STATUS_DEEP_STOP_BIT = 5;

  // Reset values.
  localparam logic [NUM_CHAN-1:0] RELOC_RESET = 4'h0;
  localparam logic [2*NUM_PINS-1:0] FUNC_RESET = 16'h0000;
  localparam logic [NUM_PINS-1:0] GPIO_OUT_RESET = 8'h00;
  localparam logic [NUM_PINS-1:0] GPIO_DIR_RESET = 8'h00;

  // Mode request codes written to the control register.
  localparam logic [2:0] MODE_RUN = 3'h0;
  localparam logic [2:0] MODE_SLEEP = 3'h1;
  localparam logic [2:0] MODE_TIMER = 3'h2;
  localparam logic [2:0] MODE_STOP = 3'h3;
  localparam logic [2:0] MODE_DEEP_TIMER = 3'h4;
  localparam logic [2:0] MODE_DEEP_STOP = 3'h5;

  // Per-pin function codes.
  localparam logic [1:0] FUNC_GPIO = 2'h0;
  localparam logic [1:0] FUNC_PERIPH = 2'h1;
  localparam logic [1:0] FUNC_ANALOG = 2'h2;
  localparam logic [1:0] FUNC_I2C = 2'h3;

  // Power state of the device as seen by the pins.
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_SLEEP = 5'h02,
    ST_LOW = 5'h04,
    ST_DEEP = 5'h08,
    ST_RETURN = 5'h10
  } pwr_state_t;

  // Extracts the function code of one pin from the packed select word.
  function automatic logic [1:0] func_of(input logic [2*NUM_PINS-1:0] sel, input int pin);
    func_of = sel[2*pin +: 2];
  endfunction : func_of

endpackage : pin_state_pkg
`default_nettype wire

// ==== logic/pin_route_if.sv ====
// Interface between the pin state core, the relocation router and the hold store.
`timescale 1ns/1ps
`default_nettype none
interface pin_route_if;
  import pin_state_pkg::*;
  logic [NUM_CHAN-1:0] reloc_sel;
  logic [NUM_CHAN-1:0] chan_out;
  logic [NUM_CHAN-1:0] chan_drive;
  logic [NUM_CHAN-1:0] chan_in;
  logic [NUM_PINS-1:0] pin_internal;
  logic [NUM_PINS-1:0] pin_periph_out;
  logic [NUM_PINS-1:0] pin_periph_drive;
  logic capture;
  logic [NUM_PINS-1:0] live_out;
  logic [NUM_PINS-1:0] live_drive;
  logic [NUM_PINS-1:0] held_out;
  logic [NUM_PINS-1:0] held_drive;

  modport router (input reloc_sel, chan_out, chan_drive, pin_internal,
                  output pin_periph_out, pin_periph_drive, chan_in);
  modport hold (input capture, live_out, live_drive, output held_out, held_drive);
  modport core (output reloc_sel, chan_out, chan_drive, pin_internal, capture, live_out, live_drive,
                input pin_periph_out, pin_periph_drive, chan_in, held_out, held_drive);
endinterface : pin_route_if
`default_nettype wire

// ==== logic/pin_relocation_router.sv ====
// Routes each peripheral channel to the one pin chosen by the relocation select.
`timescale 1ns/1ps
`default_nettype none
module pin_relocation_router
  import pin_state_pkg::*;
(
  // Routing signals.
  pin_route_if.router rt
);

  // Pin p carries channel p mod NUM_CHAN, on its alternate site when p is in the upper half.
  always_comb begin
    rt.pin_periph_out = '0;
    rt.pin_periph_drive = '0;
    rt.chan_in = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (rt.reloc_sel[p % NUM_CHAN] == (p >= NUM_CHAN)) begin
        rt.pin_periph_out[p] = rt.chan_out[p % NUM_CHAN];
        rt.pin_periph_drive[p] = rt.chan_drive[p % NUM_CHAN];
        rt.chan_in[p % NUM_CHAN] = rt.pin_internal[p];
      end
    end
  end

endmodule : pin_relocation_router
`default_nettype wire

// ==== logic/pin_hold_store.sv ====
// Remembers each pin's output level and drive at the moment of a standby mode entry, not sleep.
`timescale 1ns/1ps
`default_nettype none
module pin_hold_store
  import pin_state_pkg::*;
(
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rst_in,
  // Capture strobe and values.
  pin_route_if.hold hd
);

  // Captured on the entry pulse only, so the held state is the one just before the mode change.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      hd.held_out <= '0;
      hd.held_drive <= '0;
    end else if (hd.capture) begin
      hd.held_out <= hd.live_out;
      hd.held_drive <= hd.live_drive;
    end
  end

endmodule : pin_hold_store
`default_nettype wire

// ==== logic/pin_state_control.sv ====
// Pin state control: register slave, power state tracking and per-pin drive selection.
`timescale 1ns/1ps
`default_nettype none
//
// Operation
// - Relocated channel goes to selected pin only.
// - I2C pins never drive high.
// - External reset active while pin low.
// - Standby level bit: keep, or Hi-Z.
// - Fixed-input state reads constant low, except wakeup pin 0 while enabled.
// - Hi-Z state disables output driver.
// - Keep state: peripheral follows in timer and stop, port held.
// - Deep standby holds peripheral pins like port pins.
// - Sub oscillator input always enabled.
// - External sub clock becomes GPIO after deep stop.
module pin_state_control
  import pin_state_pkg::*;
(
  // Clock and resets.
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic external_reset_n_in,
  // Avalon-MM slave.
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Package pins.
  input wire logic [NUM_PINS-1:0] pin_in_in,
  output logic [NUM_PINS-1:0] pin_out_out,
  output logic [NUM_PINS-1:0] pin_oe_n_out,
  // Peripheral channels.
  input wire logic [NUM_CHAN-1:0] chan_out_in,
  input wire logic [NUM_CHAN-1:0] chan_drive_in,
  output logic [NUM_CHAN-1:0] chan_in_out,
  // Oscillator pin control.
  output logic sub_osc_input_en_out,
  output logic sub_clk_ext_sel_out
);

  // Combined reset: the board reset pin is asynchronous like the system reset.
  logic core_rst;

  // Register contents.
  logic spl_q; // Standby pin level bit.
  logic wake_en_q; // Wakeup pin 0 enable.
  logic sub_ext_q; // External sub clock selected on the sub clock port pin.
  logic [NUM_CHAN-1:0] reloc_q; // Relocation select, one bit per channel.
  logic [2*NUM_PINS-1:0] func_q; // Function code per pin.
  logic [NUM_PINS-1:0] gpio_out_q; // Port output levels.
  logic [NUM_PINS-1:0] gpio_dir_q; // Port direction, 1 drives.

  // Bus handshake state.
  logic ack_q; // High in the cycle the answer is presented.
  logic [31:0] rdata_d; // Read mux result.

  // Power state.
  pwr_state_t state_q;
  pwr_state_t state_d;
  logic deep_stop_q; // Current deep standby was entered as deep stop.
  logic mode_wr; // Accepted write to the control register.
  logic [2:0] mode_req; // Mode field of that write.
  logic wake_event; // Wakeup pin seen high while enabled.

  // Per-pin next values.
  logic [NUM_PINS-1:0] pin_out_d;
  logic [NUM_PINS-1:0] pin_drive_d;
  logic [NUM_PINS-1:0] pin_internal_d;
  logic [NUM_PINS-1:0] pin_internal_q;

  // Shared routing and hold signals.
  pin_route_if rif ();

  assign core_rst = rst_in | ~external_reset_n_in;

  // Router that resolves which pin a relocated channel uses.
  pin_relocation_router u_router (
    .rt(rif.router)
  );

  // Store of the pin state taken at low-power entry.
  pin_hold_store u_hold (
    .clock_in(clock_in),
    .rst_in(core_rst),
    .hd(rif.hold)
  );

  assign rif.reloc_sel = reloc_q;
  assign rif.chan_out = chan_out_in;
  assign rif.chan_drive = chan_drive_in;
  assign rif.pin_internal = pin_internal_q;
  assign rif.live_out = pin_out_out;
  assign rif.live_drive = ~pin_oe_n_out;

  // Capture the live pin state exactly when leaving run or sleep for a standby mode.
  assign rif.capture = (state_q == ST_RUN || state_q == ST_SLEEP) &&
                       (state_d == ST_LOW || state_d == ST_DEEP);

  // Waitrequest drops for one cycle, one cycle after the request appears.
  always_ff @(posedge clock_in or posedge core_rst) begin
    if (core_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
    end
  end

  // Waitrequest is a plain register inversion, high through reset.
  always_ff @(posedge clock_in or posedge core_rst) begin
    if (core_rst) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~ack_q);
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (avs_address_in)
      CTRL_OFFSET: begin
        rdata_d[CTRL_SPL_BIT] = spl_q;
        rdata_d[CTRL_WAKE_BIT] = wake_en_q;
        rdata_d[CTRL_SUBEXT_BIT] = sub_ext_q;
      end
      RELOC_OFFSET: rdata_d[NUM_CHAN-1:0] = reloc_q;
      FUNC_OFFSET: rdata_d[2*NUM_PINS-1:0] = func_q;
      GPIO_OUT_OFFSET: rdata_d[NUM_PINS-1:0] = gpio_out_q;
      GPIO_DIR_OFFSET: rdata_d[NUM_PINS-1:0] = gpio_dir_q;
      PIN_IN_OFFSET: rdata_d[NUM_PINS-1:0] = pin_internal_q;
      STATUS_OFFSET: begin
        rdata_d[4:0] = state_q;
        rdata_d[STATUS_DEEP_STOP_BIT] = deep_stop_q;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data is loaded in the same edge that lowers waitrequest, so it stands when sampled.
  always_ff @(posedge clock_in or posedge core_rst) begin
    if (core_rst) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in & ~ack_q) begin
      avs_readdata_out <= rdata_d;
    end
  end

  // A write takes effect on the edge where the master sees waitrequest low.
  assign mode_wr = avs_write_in & ack_q & (avs_address_in == CTRL_OFFSET);
  assign mode_req = avs_writedata_in[CTRL_MODE_LSB +: 3];

  // Control bits; the board reset clears them, so the level bit reads 0 afterwards.
  always_ff @(posedge clock_in or posedge core_rst) begin
    if (core_rst) begin
      spl_q <= 1'b0;
      wake_en_q <= 1'b0;
    end else if (mode_wr) begin
      spl_q <= avs_writedata_in[CTRL_SPL_BIT];
      wake_en_q <= avs_writedata_in[CTRL_WAKE_BIT];
    end
  end

  // External sub clock select; hardware drops it back to port use after deep stop.
  always_ff @(posedge clock_in or posedge core_rst) begin
    if (core_rst) begin
      sub_ext_q <= 1'b0;
    end else if (state_q == ST_DEEP && state_d == ST_RETURN && deep_stop_q) begin
      sub_ext_q <= 1'b0;
    end else if (mode_wr) begin
      sub_ext_q <= avs_writedata_in[CTRL_SUBEXT_BIT];
    end
  end

  // Pin function, relocation and port registers.
  always_ff @(posedge clock_in or posedge core_rst) begin
    if (core_rst) begin
      reloc_q <= RELOC_RESET;
      func_q <= FUNC_RESET;
      gpio_out_q <= GPIO_OUT_RESET;
      gpio_dir_q <= GPIO_DIR_RESET;
    end else if (avs_write_in & ack_q) begin
      if (avs_address_in == RELOC_OFFSET) begin
        reloc_q <= avs_writedata_in[NUM_CHAN-1:0];
      end
      if (avs_address_in == FUNC_OFFSET) begin
        func_q <= avs_writedata_in[2*NUM_PINS-1:0];
      end
      // Software must make the clock-sharing ports inputs here before applying a clock.
      if (avs_address_in == GPIO_OUT_OFFSET) begin
        gpio_out_q <= avs_writedata_in[NUM_PINS-1:0];
      end
      if (avs_address_in == GPIO_DIR_OFFSET) begin
        gpio_dir_q <= avs_writedata_in[NUM_PINS-1:0];
      end
    end
  end

  // The wakeup pin only counts when enabled; it is read through the registered input path.
  assign wake_event = wake_en_q & pin_internal_q[0];

  // Power state transitions from software requests and the wakeup pin.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN: begin
        if (mode_wr) begin
          if (mode_req == MODE_SLEEP) begin
            state_d = ST_SLEEP;
          end else if (mode_req == MODE_TIMER || mode_req == MODE_STOP) begin
            state_d = ST_LOW;
          end else if (mode_req == MODE_DEEP_TIMER || mode_req == MODE_DEEP_STOP) begin
            state_d = ST_DEEP;
          end
        end
      end
      ST_SLEEP: begin
        if (wake_event || (mode_wr && mode_req == MODE_RUN)) begin
          state_d = ST_RUN;
        end
      end
      ST_LOW: begin
        if (wake_event) begin
          state_d = ST_RUN;
        end
      end
      // Deep standby ends in the return state, not in run.
      ST_DEEP: begin
        if (wake_event) begin
          state_d = ST_RETURN;
        end
      end
      ST_RETURN: begin
        if (mode_wr && mode_req == MODE_RUN) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // State register.
  always_ff @(posedge clock_in or posedge core_rst) begin
    if (core_rst) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Remembers whether the current deep standby is the stop flavour.
  always_ff @(posedge clock_in or posedge core_rst) begin
    if (core_rst) begin
      deep_stop_q <= 1'b0;
    end else if (state_q == ST_RUN && state_d == ST_DEEP) begin
      deep_stop_q <= (mode_req == MODE_DEEP_STOP);
    end else if (state_d == ST_RUN) begin
      deep_stop_q <= 1'b0;
    end
  end

  // Per-pin drive and input selection from function, power state and level bit.
  always_comb begin
    pin_out_d = '0;
    pin_drive_d = '0;
    pin_internal_d = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      logic [1:0] fn;
      logic live_out;
      logic live_drive;
      fn = func_of(func_q, p);
      live_out = (fn == FUNC_GPIO) ? gpio_out_q[p] : rif.pin_periph_out[p];
      live_drive = (fn == FUNC_GPIO) ? gpio_dir_q[p] : rif.pin_periph_drive[p];
      if (fn == FUNC_ANALOG) begin
        pin_internal_d[p] = 1'b0;
        pin_drive_d[p] = 1'b0;
      end else if (state_q == ST_RUN || state_q == ST_SLEEP) begin
        pin_out_d[p] = live_out;
        pin_drive_d[p] = live_drive;
        pin_internal_d[p] = pin_in_in[p];
      end else if (spl_q && state_q != ST_RETURN) begin
        pin_drive_d[p] = 1'b0;
        // The wakeup pin keeps listening so the device can leave standby.
        pin_internal_d[p] = (p == 0) ? (wake_en_q & pin_in_in[p]) : 1'b0;
      end else if (state_q == ST_LOW && fn != FUNC_GPIO) begin
        pin_out_d[p] = live_out;
        pin_drive_d[p] = live_drive;
        pin_internal_d[p] = pin_in_in[p];
      end else begin
        pin_out_d[p] = rif.held_out[p];
        pin_drive_d[p] = rif.held_drive[p];
        pin_internal_d[p] = pin_in_in[p];
      end
      if (fn == FUNC_I2C) begin
        pin_drive_d[p] = pin_drive_d[p] & ~pin_out_d[p];
        pin_out_d[p] = 1'b0;
      end
    end
  end

  // Pin outputs come straight from flops; reset leaves every pin undriven.
  always_ff @(posedge clock_in or posedge core_rst) begin
    if (core_rst) begin
      pin_out_out <= '0;
      pin_oe_n_out <= '1;
      pin_internal_q <= '0;
    end else begin
      pin_out_out <= pin_out_d;
      pin_oe_n_out <= ~pin_drive_d;
      pin_internal_q <= pin_internal_d;
    end
  end

  // Channel inputs are registered after routing.
  always_ff @(posedge clock_in or posedge core_rst) begin
    if (core_rst) begin
      chan_in_out <= '0;
    end else begin
      chan_in_out <= rif.chan_in;
    end
  end

  // The crystal input must never be gated, not even in reset or deep standby.
  always_ff @(posedge clock_in or posedge core_rst) begin
    if (core_rst) begin
      sub_osc_input_en_out <= 1'b1;
    end else begin
      sub_osc_input_en_out <= 1'b1;
    end
  end

  // Sub clock select seen by the oscillator pad.
  always_ff @(posedge clock_in or posedge core_rst) begin
    if (core_rst) begin
      sub_clk_ext_sel_out <= 1'b0;
    end else begin
      sub_clk_ext_sel_out <= sub_ext_q;
    end
  end

endmodule : pin_state_control
`default_nettype wire

// ==== dv/pin_state_monitor.sv ====
// Checker of the pin state control ports.
`timescale 1ns/1ps
`default_nettype none
module pin_state_monitor
  import pin_state_pkg::*;
(
  // Clock and resets.
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic external_reset_n_in,
  // Bus.
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // Pins and oscillator.
  input wire logic [NUM_PINS-1:0] pin_out_out,
  input wire logic [NUM_PINS-1:0] pin_oe_n_out,
  input wire logic [NUM_CHAN-1:0] chan_in_out,
  input wire logic sub_osc_input_en_out,
  input wire logic sub_clk_ext_sel_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in || !external_reset_n_in);
  // Accepted write and shadows of the function word and the sub clock bit.
  logic acc;
  logic [15:0] func_q;
  logic wd5_q;
  logic [NUM_PINS-1:0] i2c_c, ana_c, i2c_q, ana_q;
  assign acc = avs_write_in && !avs_waitrequest_out;
  // Shadow registers follow accepted writes, as the design's own registers do.
  always_ff @(posedge clock_in or posedge rst_in or negedge external_reset_n_in) begin
    if (rst_in || !external_reset_n_in) begin
      func_q <= '0;
      wd5_q <= 1'b0;
    end else begin
      if (acc && avs_address_in == FUNC_OFFSET) func_q <= avs_writedata_in[15:0];
      if (acc && avs_address_in == CTRL_OFFSET) wd5_q <= avs_writedata_in[CTRL_SUBEXT_BIT];
    end
  end
  // Masks now and one cycle late, so either pin timing is accepted.
  always_comb begin
    for (int k = 0; k < NUM_PINS; k++) begin
      i2c_c[k] = func_q[2*k +: 2] == FUNC_I2C;
      ana_c[k] = func_q[2*k +: 2] == FUNC_ANALOG;
    end
  end
  always_ff @(posedge clock_in or posedge rst_in or negedge external_reset_n_in) begin
    if (rst_in || !external_reset_n_in) begin
      i2c_q <= '0;
      ana_q <= '0;
    end else begin
      i2c_q <= i2c_c;
      ana_q <= ana_c;
    end
  end
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ans;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  property p_answer;
    s_req |=> s_ans;
  endproperty
  property p_idle;
    !avs_read_in && !avs_write_in && avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  property p_osc;
    disable iff (rst_in) sub_osc_input_en_out;
  endproperty
  property p_rst_pins;
    disable iff (rst_in) !external_reset_n_in |-> pin_oe_n_out == '1 && chan_in_out == '0;
  endproperty
  property p_rst_regs;
    disable iff (rst_in) !external_reset_n_in |-> avs_waitrequest_out && avs_readdata_out == '0 && !sub_clk_ext_sel_out;
  endproperty
  property p_i2c;
    (pin_out_out & i2c_q & i2c_c) == '0;
  endproperty
  property p_analog;
    (~pin_oe_n_out & ana_q & ana_c) == '0;
  endproperty
  property p_subext;
    acc && avs_address_in == CTRL_OFFSET |-> ##[1:2] sub_clk_ext_sel_out == wd5_q;
  endproperty
  a_answer: assert property (p_answer) else $error("waitrequest answer wrong");
  a_idle: assert property (p_idle) else $error("waitrequest dropped without request");
  a_osc: assert property (p_osc) else $error("sub oscillator input disabled");
  a_rst_pins: assert property (p_rst_pins) else $error("pins active in reset");
  a_rst_regs: assert property (p_rst_regs) else $error("state not cleared in reset");
  a_i2c: assert property (p_i2c) else $error("I2C pin output high");
  a_analog: assert property (p_analog) else $error("analog pin driven");
  a_subext: assert property (p_subext) else $error("sub clock select not written");
endmodule : pin_state_monitor
bind pin_state_control pin_state_monitor u_pin_state_monitor (.clock_in(clock_in), .rst_in(rst_in),
  .external_reset_n_in(external_reset_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .pin_out_out(pin_out_out), .pin_oe_n_out(pin_oe_n_out),
  .chan_in_out(chan_in_out), .sub_osc_input_en_out(sub_osc_input_en_out),
  .sub_clk_ext_sel_out(sub_clk_ext_sel_out));
`default_nettype wire

// ==== dv/board_model.sv ====
// Board side of the package pins.
`timescale 1ns/1ps
`default_nettype none
module board_model
  import pin_state_pkg::*;
(
  // Device pin side.
  input wire logic [NUM_PINS-1:0] pin_out_in,
  input wire logic [NUM_PINS-1:0] pin_oe_n_in,
  // Level the board puts on a released pad.
  input wire logic [NUM_PINS-1:0] board_level_in,
  // Level at each pad.
  output logic [NUM_PINS-1:0] pad_out
);
  // A released pad shows the board level, never a stale device level.
  assign pad_out = (pin_out_in & ~pin_oe_n_in) | (board_level_in & pin_oe_n_in);
endmodule : board_model
`default_nettype wire

// ==== dv/pin_state_control_tb.sv ====
// Self-checking bench for the pin state control block.
`timescale 1ns/1ps
`default_nettype none
module pin_state_control_tb;
  import pin_state_pkg::*;
  logic clock_in, rst_in, ext_n, rd_s, wr_s, waitreq, osc_en, ext_sel;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, got, seed;
  logic [7:0] pad, pout, poe_n, brd, m_out, m_dir;
  logic [3:0] ch_out, ch_drv, ch_in, m_reloc;
  logic [15:0] m_func;
  int failures, cmp_count;
  pin_state_control u_pin_state_control (.clock_in(clock_in), .rst_in(rst_in), .external_reset_n_in(ext_n),
    .avs_address_in(addr), .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .pin_in_in(pad), .pin_out_out(pout),
    .pin_oe_n_out(poe_n), .chan_out_in(ch_out), .chan_drive_in(ch_drv), .chan_in_out(ch_in),
    .sub_osc_input_en_out(osc_en), .sub_clk_ext_sel_out(ext_sel));
  board_model u_board_model (.pin_out_in(pout), .pin_oe_n_in(poe_n), .board_level_in(brd), .pad_out(pad));
  // Free running clock.
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs
  task automatic report_and_stop;
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    cmp_count++;
    if ((g & m) !== (e & m)) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One bus cycle; the request stands until waitrequest is seen low at an edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    addr <= a;
    wdata <= d;
    wr_s <= w;
    rd_s <= !w;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (waitreq !== 1'b0 && n < 40);
    got = rdata;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
    @(posedge clock_in);
    if (n >= 40) begin
      failures++;
      $display("Error at %0t: bus answer timed out", $time);
      report_and_stop();
    end
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk(got, e, m);
  endtask : rd
  // Reads the state until it matches, a bounded number of times.
  task automatic poll(input logic [31:0] e);
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, STATUS_OFFSET, 32'h0);
      if (got[4:0] === e[4:0]) break;
    end
    chk(got, e, 32'h1f);
    // A state that never arrives ends the run here rather than derailing later steps.
    if (got[4:0] !== e[4:0]) report_and_stop();
  endtask : poll
  // Expected pins from the model: function, relocation, port and channel levels.
  task automatic chk_pins(input bit full);
    logic [7:0] eo, eoe, km, om, ew, ei, im;
    logic [3:0] ec, cm;
    logic [1:0] f;
    int c;
    {eo, eoe, km, om, ei, im, ec, cm} = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      f = m_func[2*p +: 2];
      c = p % NUM_CHAN;
      ew[p] = brd[p];
      if (f == FUNC_GPIO) begin
        {eoe[p], eo[p], om[p], km[p], im[p]} = {!m_dir[p], m_out[p], m_dir[p], 2'b11};
        if (m_dir[p]) ew[p] = m_out[p];
      end else if (f == FUNC_PERIPH && m_reloc[c] == (p >= 4)) begin
        {eoe[p], eo[p], om[p], km[p]} = {!ch_drv[c], ch_out[c], ch_drv[c], 1'b1};
        if (ch_drv[c]) ew[p] = ch_out[c];
        {ec[c], cm[c]} = {ew[p], 1'b1};
      end else if (f == FUNC_ANALOG) begin
        {eoe[p], km[p], im[p]} = 3'b111;
      end else if (f == FUNC_I2C) begin
        om[p] = 1'b1;
      end
      ei[p] = (f == FUNC_GPIO) ? ew[p] : 1'b0;
    end
    chk(poe_n, eoe, km);
    chk(pout, eo, om);
    chk(osc_en, 32'h1, 32'h1);
    if (full) begin
      chk(ch_in, ec, cm);
      rd(PIN_IN_OFFSET, ei, im);
    end
  endtask : chk_pins
  // A random run configuration; pin0 stays a port input for waking.
  task automatic rnd_cfg;
    seed = xs(seed);
    m_func = seed[15:0] & 16'hfffc;
    m_reloc = seed[19:16];
    seed = xs(seed);
    {m_out, m_dir} = {seed[7:0], seed[15:8] & 8'hfe};
    {ch_out, ch_drv, brd} <= {seed[19:16], seed[23:20], seed[31:24] & 8'hfe};
    bus(1'b1, FUNC_OFFSET, {16'h0, m_func});
    bus(1'b1, RELOC_OFFSET, {28'h0, m_reloc});
    bus(1'b1, GPIO_OUT_OFFSET, {24'h0, m_out});
    bus(1'b1, GPIO_DIR_OFFSET, {24'h0, m_dir});
    rd(FUNC_OFFSET, {16'h0, m_func}, 32'hffffffff);
    repeat (3) @(posedge clock_in);
    chk_pins(1'b1);
  endtask : rnd_cfg
  // Hang guard.
  initial begin
    repeat (20000) @(posedge clock_in);
    failures++;
    $display("Error at %0t: run timed out", $time);
    report_and_stop();
  end
  // Main sequence.
  initial begin
    {rst_in, ext_n, rd_s, wr_s, addr, wdata, ch_out, ch_drv, brd} = {2'b11, 2'b00, 5'h0, 32'h0, 16'h0};
    {m_func, m_reloc, m_out, m_dir, seed, failures, cmp_count} = {36'h0, 32'h18c9, 64'h0};
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    for (int i = 0; i < 8; i++) rd(5'(4 * i), (i == 6) ? 32'h1 : 32'h0, 32'hffffffff);
    for (int i = 5; i < 8; i++) begin
      bus(1'b1, 5'(4 * i), 32'hffffffff);
      rd(5'(4 * i), (i == 6) ? 32'h1 : 32'h0, 32'hffffffff);
    end
    chk_pins(1'b1);
    repeat (12) rnd_cfg();
    for (int m = 1; m <= 5; m++) begin
      if (m == 5) begin
        m_dir = 8'h00;
        bus(1'b1, GPIO_DIR_OFFSET, 32'h0);
      end
      bus(1'b1, CTRL_OFFSET, 32'h10 | 32'(m << CTRL_MODE_LSB) | ((m >= 4) ? 32'h20 : 32'h0));
      poll((m == 1) ? 32'h2 : (m < 4) ? 32'h4 : 32'h8);
      if (m > 1) begin
        bus(1'b1, GPIO_OUT_OFFSET, {24'h0, ~m_out});
        if (m < 4) ch_out <= ~ch_out;
        repeat (3) @(posedge clock_in);
        chk_pins(1'b0);
      end
      brd[0] <= 1'b1;
      poll((m < 4) ? 32'h1 : 32'h10);
      if (m >= 4) begin
        chk(ext_sel, (m == 4) ? 32'h1 : 32'h0, 32'h1);
        bus(1'b1, CTRL_OFFSET, 32'h0);
        poll(32'h1);
      end
      brd[0] <= 1'b0;
      if (m > 1) m_out = ~m_out;
      repeat (3) @(posedge clock_in);
      chk_pins(1'b1);
    end
    bus(1'b1, CTRL_OFFSET, 32'h11 | 32'(MODE_STOP << CTRL_MODE_LSB));
    repeat (3) @(posedge clock_in);
    chk(poe_n, 32'hff, 32'hff);
    rd(PIN_IN_OFFSET, 32'h0, 32'hfe);
    brd[0] <= 1'b1;
    poll(32'h1);
    brd[0] <= 1'b0;
    ext_n <= 1'b0;
    repeat (3) @(posedge clock_in);
    chk(poe_n, 32'hff, 32'hff);
    ext_n <= 1'b1;
    @(posedge clock_in);
    rd(CTRL_OFFSET, 32'h0, 32'hffffffff);
    rd(FUNC_OFFSET, 32'h0, 32'hffffffff);
    report_and_stop();
  end
endmodule : pin_state_control_tb
`default_nettype wire
